// ---- src/pfc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the port flow control registers.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_ADDR_W 12
`define PFC_P1_OFFSET 12'h1A0
`define PFC_P2_OFFSET 12'h1A4

`define PFC_BIT_BP 6
`define PFC_BIT_DUP 5
`define PFC_BIT_RXACT 4
`define PFC_BIT_TXACT 3
`define PFC_BIT_RXEN 2
`define PFC_BIT_TXEN 1
`define PFC_BIT_MAN 0
`define PFC_RSVD_HI 31
`define PFC_RSVD_LO 7
`define PFC_RSVD_VALUE 25'h0000000

`define PFC_CTRL_RESET 4'h0
`define PFC_STAT_RESET 3'h0
`define PFC_PRDATA_RESET 32'h00000000
`define PFC_SETTLE_CYCLES 2'h3
`define PFC_SETTLE_ZERO 2'h0

`endif

// ---- src/pfc_pkg.sv ----
// Types and shared functions of the port flow control register bank.
// Assumes pfc_cfg.svh is reachable on the include path.
package pfc_pkg;
  `include "pfc_cfg.svh"

  typedef struct packed {
    logic backpressure;
    logic rx_enable;
    logic tx_enable;
    logic manual;
  } pfc_ctrl_t;

  typedef struct packed {
    logic half_duplex;
    logic rx_active;
    logic tx_active;
  } pfc_stat_t;

  typedef struct packed {
    logic half_duplex;
    logic an_enable;
    logic an_rx_pause;
    logic an_tx_pause;
  } pfc_link_t;

  typedef struct packed {
    logic backpressure;
    logic pause;
    logic select;
    logic half_duplex;
    logic an_enable;
  } pfc_strap_t;

  typedef enum logic [1:0] {
    PFC_SETTLE = 2'b00,
    PFC_LOAD = 2'b01,
    PFC_RUN = 2'b10
  } pfc_state_t;

  // Pause applies only in full duplex; manual bits win when selected or negotiation is off
  function automatic pfc_stat_t pfc_resolve(input pfc_ctrl_t c, input pfc_link_t l);
    pfc_stat_t s;
    s.half_duplex = l.half_duplex;
    if (l.half_duplex) begin
      s.rx_active = 1'b0;
      s.tx_active = 1'b0;
    end else if (c.manual || !l.an_enable) begin
      s.rx_active = c.rx_enable;
      s.tx_active = c.tx_enable;
    end else begin
      s.rx_active = l.an_rx_pause;
      s.tx_active = l.an_tx_pause;
    end
    return s;
  endfunction

  function automatic logic [31:0] pfc_pack(input pfc_ctrl_t c, input pfc_stat_t s);
    logic [31:0] w;
    w = 32'h00000000;
    w[`PFC_RSVD_HI:`PFC_RSVD_LO] = `PFC_RSVD_VALUE;
    w[`PFC_BIT_BP] = c.backpressure;
    w[`PFC_BIT_DUP] = s.half_duplex;
    w[`PFC_BIT_RXACT] = s.rx_active;
    w[`PFC_BIT_TXACT] = s.tx_active;
    w[`PFC_BIT_RXEN] = c.rx_enable;
    w[`PFC_BIT_TXEN] = c.tx_enable;
    w[`PFC_BIT_MAN] = c.manual;
    return w;
  endfunction

  function automatic pfc_ctrl_t pfc_unpack(input logic [31:0] w);
    pfc_ctrl_t c;
    c.backpressure = w[`PFC_BIT_BP];
    c.rx_enable = w[`PFC_BIT_RXEN];
    c.tx_enable = w[`PFC_BIT_TXEN];
    c.manual = w[`PFC_BIT_MAN];
    return c;
  endfunction

  function automatic pfc_ctrl_t pfc_strap_ctrl(input pfc_strap_t p);
    pfc_ctrl_t c;
    c.backpressure = p.backpressure;
    c.rx_enable = p.pause;
    c.tx_enable = p.pause;
    c.manual = p.select;
    return c;
  endfunction

  function automatic pfc_link_t pfc_strap_link(input pfc_strap_t p);
    pfc_link_t l;
    l.half_duplex = p.half_duplex;
    l.an_enable = p.an_enable;
    l.an_rx_pause = p.pause;
    l.an_tx_pause = p.pause;
    return l;
  endfunction
endpackage

// ---- src/pfc_port.sv ----
// One port's writable flow control fields and current status.
// Assumes load and wr are single-cycle pulses from the bank on the same clock.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_port
  import pfc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencing from the bank
  input wire logic load,
  input wire logic run,
  input wire pfc_strap_t strap,
  // Software write
  input wire logic wr,
  input wire pfc_ctrl_t wfields,
  // Live port condition
  input wire pfc_link_t link,
  // State
  output pfc_ctrl_t ctrl,
  output pfc_stat_t stat
);
  pfc_ctrl_t ctrl_r;
  pfc_ctrl_t ctrl_nxt;
  pfc_stat_t stat_r;
  pfc_stat_t stat_nxt;

  // Writes touch only this bank; the advertisement in the PHY is never driven from here
  assign ctrl_nxt = load ? pfc_strap_ctrl(strap) : (wr ? wfields : ctrl_r);
  assign stat_nxt = load ? pfc_resolve(pfc_strap_ctrl(strap), pfc_strap_link(strap)) :
                    (run ? pfc_resolve(ctrl_r, link) : stat_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `PFC_CTRL_RESET;
      stat_r <= `PFC_STAT_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign ctrl = ctrl_r;
  assign stat = stat_r;
endmodule // pfc_port

// ---- src/pfc_regs.sv ----
// APB register bank for flow control of switch ports 1 and 2.
// Assumes strap pins are asynchronous and link status comes from logic on pclk.
`timescale 1ns/1ps
`include "pfc_cfg.svh"

module pfc_regs
  import pfc_pkg::*;
#(
  parameter int ADDR_W = `PFC_ADDR_W
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Port 1 straps
  input wire logic p1_backpressure_pin_default,
  input wire logic p1_pause_pin_default,
  input wire logic p1_select_pin_default,
  input wire logic p1_duplex_pin_default,
  input wire logic p1_autoneg_pin_default,
  // Port 2 straps
  input wire logic p2_backpressure_pin_default,
  input wire logic p2_pause_pin_default,
  input wire logic p2_select_pin_default,
  input wire logic p2_duplex_pin_default,
  input wire logic p2_autoneg_pin_default,
  // Live link condition
  input wire pfc_link_t p1_link,
  input wire pfc_link_t p2_link,
  // Flow control to the ports
  output logic p1_backpressure_gen,
  output logic p1_rx_pause_active,
  output logic p1_tx_pause_active,
  output logic p2_backpressure_gen,
  output logic p2_rx_pause_active,
  output logic p2_tx_pause_active
);
  pfc_state_t state_r;
  pfc_state_t state_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  // Ready lags run by one cycle so the read capture sees loaded fields
  logic ready_r;
  pfc_strap_t strap_meta_r [2];
  pfc_strap_t strap_sync_r [2];
  pfc_strap_t strap_pin [2];
  pfc_link_t link [2];
  pfc_ctrl_t ctrl [2];
  pfc_stat_t stat [2];
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  wire hit1;
  wire hit2;
  wire hit;
  wire access;
  wire write_ok;
  wire wr1;
  wire wr2;
  wire load;
  wire run;
  wire [31:0] rd_word;
  pfc_ctrl_t wfields;

  assign strap_pin[0] = '{p1_backpressure_pin_default, p1_pause_pin_default, p1_select_pin_default,
                          p1_duplex_pin_default, p1_autoneg_pin_default};
  assign strap_pin[1] = '{p2_backpressure_pin_default, p2_pause_pin_default, p2_select_pin_default,
                          p2_duplex_pin_default, p2_autoneg_pin_default};
  assign link[0] = p1_link;
  assign link[1] = p2_link;

  // Straps are pins: two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_r[0] <= '0;
      strap_meta_r[1] <= '0;
      strap_sync_r[0] <= '0;
      strap_sync_r[1] <= '0;
    end else begin
      strap_meta_r <= strap_pin;
      strap_sync_r <= strap_meta_r;
    end
  end

  // Straps are caught after release; the bus stalls until then
  assign settle_nxt = (state_r == PFC_SETTLE) ? settle_r + 2'h1 : settle_r;
  always_comb begin
    case (state_r)
      PFC_SETTLE: state_nxt = (settle_r == `PFC_SETTLE_CYCLES) ? PFC_LOAD : PFC_SETTLE;
      PFC_LOAD: state_nxt = PFC_RUN;
      PFC_RUN: state_nxt = PFC_RUN;
      default: state_nxt = PFC_SETTLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PFC_SETTLE;
      settle_r <= `PFC_SETTLE_ZERO;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      ready_r <= run;
    end
  end

  assign load = (state_r == PFC_LOAD);
  assign run = (state_r == PFC_RUN);

  // APB decode
  assign hit1 = (paddr == ADDR_W'(`PFC_P1_OFFSET));
  assign hit2 = (paddr == ADDR_W'(`PFC_P2_OFFSET));
  assign hit = hit1 || hit2;
  assign access = psel && penable && pready;
  // Only byte lane 0 holds fields; upper lanes are reserved
  assign write_ok = access && pwrite && pstrb[0];
  assign wr1 = write_ok && hit1;
  assign wr2 = write_ok && hit2;
  assign wfields = pfc_unpack(pwdata);
  // A read stalled through reset would otherwise complete with the pre-load word
  assign pready = run && ready_r;
  assign pslverr = psel && penable && pready && !hit;

  assign rd_word = hit1 ? pfc_pack(ctrl[0], stat[0]) : (hit2 ? pfc_pack(ctrl[1], stat[1]) : 32'h00000000);
  // Keeps following the addressed word until the edge before the completing edge
  assign prdata_nxt = (psel && !pwrite && !access) ? rd_word : prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `PFC_PRDATA_RESET;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end
  assign prdata = prdata_r;

  pfc_port u_port1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .run(run),
    .strap(strap_sync_r[0]),
    .wr(wr1),
    .wfields(wfields),
    .link(link[0]),
    .ctrl(ctrl[0]),
    .stat(stat[0])
  );

  pfc_port u_port2 (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .run(run),
    .strap(strap_sync_r[1]),
    .wr(wr2),
    .wfields(wfields),
    .link(link[1]),
    .ctrl(ctrl[1]),
    .stat(stat[1])
  );

  // Backpressure only means something in half duplex
  assign p1_backpressure_gen = ctrl[0].backpressure && stat[0].half_duplex;
  assign p2_backpressure_gen = ctrl[1].backpressure && stat[1].half_duplex;
  assign p1_rx_pause_active = stat[0].rx_active;
  assign p1_tx_pause_active = stat[0].tx_active;
  assign p2_rx_pause_active = stat[1].rx_active;
  assign p2_tx_pause_active = stat[1].tx_active;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_bus_stalled_settle: assert property (!run |-> !pready)
    else $error("bus answered before straps were loaded");
  a_write_fields_p1: assert property (wr1 |=> ctrl[0] == pfc_unpack($past(pwdata)))
    else $error("port 1 write did not store fields");
  a_write_fields_p2: assert property (wr2 |=> ctrl[1] == pfc_unpack($past(pwdata)))
    else $error("port 2 write did not store fields");
  a_write_ignored_lane: assert property (access && pwrite && !pstrb[0] |=> $stable(ctrl[0]) && $stable(ctrl[1]))
    else $error("write without lane 0 changed fields");
  a_reserved_zero: assert property (access && !pwrite |-> prdata[31:7] == 25'h0000000)
    else $error("reserved bits read nonzero");
  a_duplex_follow: assert property (run ##1 run |-> stat[0].half_duplex == $past(p1_link.half_duplex))
    else $error("duplex status does not follow link");
  a_auto_result: assert property (run && !ctrl[0].manual && p1_link.an_enable && !p1_link.half_duplex
    |=> stat[0].rx_active == $past(p1_link.an_rx_pause) && stat[0].tx_active == $past(p1_link.an_tx_pause))
    else $error("negotiated pause not applied");
  a_manual_apply: assert property (run && (ctrl[1].manual || !p2_link.an_enable) && !p2_link.half_duplex
    |=> stat[1].rx_active == $past(ctrl[1].rx_enable) && stat[1].tx_active == $past(ctrl[1].tx_enable))
    else $error("manual pause enables not applied");
  a_half_no_pause: assert property (stat[0].half_duplex |-> !stat[0].rx_active && !stat[0].tx_active)
    else $error("pause active in half duplex");
  a_strap_defaults: assert property (load |=> ctrl[0] == pfc_strap_ctrl($past(strap_sync_r[0])))
    else $error("field defaults not taken from straps");
  a_strap_status: assert property (load |=> stat[1] ==
    pfc_resolve(pfc_strap_ctrl($past(strap_sync_r[1])), pfc_strap_link($past(strap_sync_r[1]))))
    else $error("status defaults not derived from straps");
  a_unmapped_error: assert property (psel && penable && pready && !hit |-> pslverr ##1 $stable(ctrl[0]))
    else $error("unmapped access not flagged");
  a_ready_in_time: assert property ($rose(presetn) |-> ##[1:8] pready)
    else $error("bus never became ready after reset");

  // Sequencing and bus framing
  a_load_then_run: assert property (load |=> run)
    else $error("load did not hand over to run");
  a_ready_after_load: assert property (load |=> !pready ##1 pready)
    else $error("bus ready not one cycle after run");
  a_write_in_run: assert property (wr1 || wr2 |-> run)
    else $error("write accepted before straps were loaded");
  a_error_in_access: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flagged outside access phase");
  a_unmapped_keep_p2: assert property (psel && penable && pready && !hit |=> $stable(ctrl[1]))
    else $error("unmapped write changed port 2 fields");

  // Port 2 mirrors of the port 1 checks, and the reverse
  a_duplex_follow_p2: assert property (run ##1 run |-> stat[1].half_duplex == $past(p2_link.half_duplex))
    else $error("port 2 duplex status does not follow link");
  a_auto_result_p2: assert property (run && !ctrl[1].manual && p2_link.an_enable && !p2_link.half_duplex
    |=> stat[1].rx_active == $past(p2_link.an_rx_pause) && stat[1].tx_active == $past(p2_link.an_tx_pause))
    else $error("port 2 negotiated pause not applied");
  a_manual_apply_p1: assert property (run && (ctrl[0].manual || !p1_link.an_enable) && !p1_link.half_duplex
    |=> stat[0].rx_active == $past(ctrl[0].rx_enable) && stat[0].tx_active == $past(ctrl[0].tx_enable))
    else $error("port 1 manual pause enables not applied");
  a_half_quiet_p2: assert property (stat[1].half_duplex |-> !stat[1].rx_active && !stat[1].tx_active)
    else $error("port 2 pause active in half duplex");
  a_strap_defaults_p2: assert property (load |=> ctrl[1] == pfc_strap_ctrl($past(strap_sync_r[1])))
    else $error("port 2 field defaults not taken from straps");
  a_strap_status_p1: assert property (load |=> stat[0] ==
    pfc_resolve(pfc_strap_ctrl($past(strap_sync_r[0])), pfc_strap_link($past(strap_sync_r[0]))))
    else $error("port 1 status defaults not derived from straps");

  // Fields move only on load or an addressed write
  a_fields_hold_p1: assert property (!load && !wr1 |=> $stable(ctrl[0]))
    else $error("port 1 fields changed without a write");
  a_fields_hold_p2: assert property (!load && !wr2 |=> $stable(ctrl[1]))
    else $error("port 2 fields changed without a write");

  // Read word is captured one edge before the completing edge
  a_read_fields_p1: assert property (access && !pwrite && hit1
    |-> {prdata[6], prdata[2:0]} == $past(ctrl[0]))
    else $error("port 1 read fields do not match register");
  a_read_status_p1: assert property (access && !pwrite && hit1 |-> prdata[5:3] == $past(stat[0]))
    else $error("port 1 read status does not match");
  a_read_fields_p2: assert property (access && !pwrite && hit2
    |-> {prdata[6], prdata[2:0]} == $past(ctrl[1]))
    else $error("port 2 read fields do not match register");
  a_read_status_p2: assert property (access && !pwrite && hit2 |-> prdata[5:3] == $past(stat[1]))
    else $error("port 2 read status does not match");
  a_read_unmapped: assert property (access && !pwrite && !hit |-> prdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  // A manual disable silences the port and a manual enable in full duplex drives it, whatever the link offers
  a_rx_off_p1: assert property (run && ctrl[0].manual && !ctrl[0].rx_enable |=> !p1_rx_pause_active)
    else $error("port 1 receive pause active while disabled");
  a_tx_off_p1: assert property (run && ctrl[0].manual && !ctrl[0].tx_enable |=> !p1_tx_pause_active)
    else $error("port 1 transmit pause active while disabled");
  a_rx_on_p2: assert property (run && ctrl[1].manual && ctrl[1].rx_enable && !p2_link.half_duplex
    |=> p2_rx_pause_active)
    else $error("port 2 manual receive pause not active");
  a_tx_on_p1: assert property (run && ctrl[0].manual && ctrl[0].tx_enable && !p1_link.half_duplex
    |=> p1_tx_pause_active)
    else $error("port 1 manual transmit pause not active");

  // Backpressure is a half duplex mechanism only
  a_bp_full_p1: assert property (!stat[0].half_duplex |-> !p1_backpressure_gen)
    else $error("port 1 backpressure in full duplex");
  a_bp_half_p1: assert property (ctrl[0].backpressure && stat[0].half_duplex |-> p1_backpressure_gen)
    else $error("port 1 backpressure missing in half duplex");
  a_bp_full_p2: assert property (!stat[1].half_duplex |-> !p2_backpressure_gen)
    else $error("port 2 backpressure in full duplex");

  c_manual_write: cover property (wr1 && pwdata[`PFC_BIT_MAN]);
  c_auto_pause: cover property (run && !ctrl[0].manual && p1_link.an_enable && p1_link.an_rx_pause);
  c_read_p2: cover property (access && !pwrite && hit2);
  c_unmapped: cover property (pslverr);
  c_half_backpressure: cover property (p1_backpressure_gen);
endmodule // pfc_regs

// ---- dv/pfc_regs_test.sv ----
// Self-checking bench for the port flow control register bank.
// Assumes pfc_pkg and pfc_regs are compiled first; the bench is the only APB master.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_regs_test;
  import pfc_pkg::*;

  typedef struct packed {
    logic port2;
    logic [31:0] wdata;
    pfc_link_t link;
    logic [31:0] exp;
  } pfc_row_t;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, adr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  // Straps: backpressure, pause, select, duplex, autoneg
  logic [4:0] s1, s2;
  pfc_link_t l1, l2;
  logic bp1, rx1, tx1, bp2, rx2, tx2;
  logic [2:0] outs;
  int err_total, num_checks, cyc;
  pfc_row_t rows [7];

  pfc_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .p1_backpressure_pin_default(s1[4]), .p1_pause_pin_default(s1[3]), .p1_select_pin_default(s1[2]),
    .p1_duplex_pin_default(s1[1]), .p1_autoneg_pin_default(s1[0]),
    .p2_backpressure_pin_default(s2[4]), .p2_pause_pin_default(s2[3]), .p2_select_pin_default(s2[2]),
    .p2_duplex_pin_default(s2[1]), .p2_autoneg_pin_default(s2[0]),
    .p1_link(l1), .p2_link(l2),
    .p1_backpressure_gen(bp1), .p1_rx_pause_active(rx1), .p1_tx_pause_active(tx1),
    .p2_backpressure_gen(bp2), .p2_rx_pause_active(rx2), .p2_tx_pause_active(tx2)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Whole run needs well under 1000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is seen high; if it never rises, only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    cyc = 0;
    err_total = 0;
    num_checks = 0;
    s1 = 5'b11001;
    s2 = 5'b00110;
    // Live link kept equal to what the straps imply, so defaults stay visible
    l1 = 4'b0111;
    l2 = 4'b1000;
    rows = '{'{1'b0, 32'hFFFFFFFF, 4'b0101, 32'h0000005F}, '{1'b0, 32'h00000006, 4'b0101, 32'h0000000E},
             '{1'b0, 32'h00000006, 4'b0010, 32'h0000001E}, '{1'b0, 32'h00000041, 4'b1011, 32'h00000061},
             '{1'b1, 32'h00000005, 4'b0111, 32'h00000015}, '{1'b1, 32'h00000002, 4'b0110, 32'h00000012},
             '{1'b1, 32'hFFFFFF80, 4'b0000, 32'h00000000}};
    repeat (12) @(posedge pclk);
    check({31'h0, pready}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `PFC_P1_OFFSET, 32'h0, 4'h0);
    check(rd, 32'h0000005E);
    apb(1'b0, `PFC_P2_OFFSET, 32'h0, 4'h0);
    check(rd, 32'h00000021);
    $display("Test reset defaults done");

    foreach (rows[i]) begin
      if (rows[i].port2) begin
        l2 <= rows[i].link;
      end else begin
        l1 <= rows[i].link;
      end
      adr = rows[i].port2 ? `PFC_P2_OFFSET : `PFC_P1_OFFSET;
      apb(1'b1, adr, rows[i].wdata, 4'hF);
      // Status trails the fields by one cycle
      repeat (2) @(posedge pclk);
      apb(1'b0, adr, 32'h0, 4'h0);
      check(rd, rows[i].exp);
      outs = rows[i].port2 ? {bp2, rx2, tx2} : {bp1, rx1, tx1};
      check({29'h0, outs}, {29'h0, rows[i].exp[6] & rows[i].exp[5], rows[i].exp[4], rows[i].exp[3]});
    end
    $display("Test field table done");

    apb(1'b1, 12'h1A8, 32'hFFFFFFFF, 4'hF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h1A8, 32'h0, 4'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Byte lane 0 off: write must be dropped
    apb(1'b1, `PFC_P1_OFFSET, 32'h00000000, 4'hE);
    apb(1'b0, `PFC_P1_OFFSET, 32'h0, 4'h0);
    check({31'h0, err}, 32'h0);
    check(rd, 32'h00000061);
    $display("Test unmapped and lane done");

    presetn <= 1'b0;
    s1 <= 5'b00110;
    s2 <= 5'b11001;
    l1 <= 4'b1000;
    l2 <= 4'b0111;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PFC_P1_OFFSET, 32'h0, 4'h0);
    check(rd, 32'h00000021);
    apb(1'b0, `PFC_P2_OFFSET, 32'h0, 4'h0);
    check(rd, 32'h0000005E);
    $display("Test second reset done");
    report_and_stop();
  end
endmodule // pfc_regs_test
